// ===== src/sdp_serial_port.sv
// dual-mode serial port, address select, dac load strobe and limit interrupt
`timescale 1ns/1ps
module sdp_serial_port #(
    parameter int DAC_CH = sdp_pkg::DAC_CH_DEF,
    parameter int DAC_W = sdp_pkg::DAC_W_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial clock and chip select from the host
    input wire logic sclkPin,
    input wire logic csPin_n,
    // data in / two-wire data pin
    input wire logic sdaDinIn,
    output logic sdaDinOut,
    output logic sdaDinOe,
    // data out / address select pin
    input wire logic doutAddIn,
    output logic doutAddOut,
    output logic doutAddOe,
    input wire logic addFloatIn,
    // dac load strobe
    input wire logic dac_load_strobe_n,
    // limit comparators: temperature, supply, analog input
    input wire logic [sdp_pkg::LIMIT_W-1:0] limitExceeded,
    // outputs
    output logic intPin,
    output logic [DAC_CH-1:0][DAC_W-1:0] dacCode,
    output logic [DAC_CH-1:0] dacPending
);
    import sdp_pkg::*;

    typedef struct packed {
        sdp_state_t st;
        logic [2:0] bitCnt;
        logic [7:0] rxSh;
        logic [7:0] txSh;
        logic [4:0] ptr;
        logic firstByte;
        logic rd;
        logic ackOn;
        logic nack;
        logic sdaOe;
        logic doutOe;
        logic [1:0] validCnt;
        logic addrLocked;
        logic [6:0] busAddr;
        logic intOut;
        logic [REG_COUNT-1:0][7:0] mem;
    } sdp_port_t;

    sdp_port_t r;
    sdp_port_t n;

    logic [SYNC_W-1:0] pinLvl;
    logic [SYNC_W-1:0] pinRise;
    logic [SYNC_W-1:0] pinFall;
    logic sclRise;
    logic sclFall;
    logic sclHigh;
    logic csLow;
    logic sdaLvl;
    logic startCond;
    logic stopCond;
    logic [6:0] liveAddr;
    logic [6:0] effAddr;
    logic gotByte;
    logic [7:0] gotVal;
    logic isSpi;
    logic wrEn;
    logic dacWr;
    logic [DAC_W-1:0] dacWrCode;
    logic loadPulse;

    if (DAC_W > 16 || DAC_CH * 2 > 8)
    begin : g_bad_cfg
        $error("sdp_serial_port: dac layout does not fit the register map");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    sdp_pin_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pinIn({dac_load_strobe_n, addFloatIn, doutAddIn, sdaDinIn, csPin_n,
            sclkPin}),
        .lvl(pinLvl),
        .rise(pinRise),
        .fall(pinFall)
    );

    // the host's serial clock is sampled, never used as a clock
    assign sclRise = pinRise[SI_SCLK];
    assign sclFall = pinFall[SI_SCLK];
    assign sclHigh = pinLvl[SI_SCLK];
    assign csLow = ~pinLvl[SI_CSN];
    assign sdaLvl = pinLvl[SI_SDA];
    // start and stop only count with chip select high
    assign startCond = pinFall[SI_SDA] & sclHigh & ~csLow;
    assign stopCond = pinRise[SI_SDA] & sclHigh & ~csLow;

    // ----------------------------------------------------------------
    // bus address selection
    // ----------------------------------------------------------------
    always_comb
    begin
        if (pinLvl[SI_FLOAT])
            liveAddr = ADDR_PIN_FLOAT;
        else if (pinLvl[SI_ADD])
            liveAddr = ADDR_PIN_HIGH;
        else
            liveAddr = ADDR_PIN_LOW;
    end

    // once latched the pin no longer matters
    assign effAddr = r.addrLocked ? r.busAddr : liveAddr;

    // ----------------------------------------------------------------
    // register read view
    // ----------------------------------------------------------------
    function automatic logic [7:0] readReg(
        input logic [REG_COUNT-1:0][7:0] mem,
        input logic [4:0] idx,
        input logic [LIMIT_W-1:0] lim
    );
        logic [7:0] v;
        v = mem[idx];
        if (idx == REG_STATUS)
            v = {{(8 - LIMIT_W){1'b0}}, lim};
        return v;
    endfunction

    // ----------------------------------------------------------------
    // protocol engine
    // ----------------------------------------------------------------
    always_comb
    begin
        n = r;
        gotByte = 1'b0;
        gotVal = {r.rxSh[6:0], sdaLvl};
        isSpi = 1'b0;
        wrEn = 1'b0;
        case (r.st)
            SDP_IDLE:
            begin
                n.sdaOe = 1'b0;
                n.doutOe = 1'b0;
            end
            SDP_ADDR:
            begin
                if (sclRise)
                begin
                    n.rxSh = gotVal;
                    n.bitCnt = r.bitCnt + 3'h1;
                    if (r.bitCnt == 3'h7)
                    begin
                        if (gotVal[7:1] == effAddr)
                        begin
                            n.st = SDP_AACK;
                            n.rd = gotVal[0];
                            n.ackOn = 1'b0;
                            // second matching address byte: latch on its 8th clock
                            if (!r.addrLocked)
                            begin
                                n.validCnt = r.validCnt + 2'h1;
                                if (r.validCnt + 2'h1 == ADDR_REPEATS)
                                begin
                                    n.addrLocked = 1'b1;
                                    n.busAddr = liveAddr;
                                end
                            end
                        end
                        else
                            n.st = SDP_IDLE;
                    end
                end
            end
            SDP_AACK, SDP_RXACK:
            begin
                if (sclFall)
                begin
                    n.ackOn = ~r.ackOn;
                    n.sdaOe = ~r.ackOn;
                    if (r.ackOn)
                    begin
                        n.bitCnt = 3'h0;
                        if (r.st == SDP_AACK && r.rd)
                        begin
                            n.st = SDP_TX;
                            n.txSh = readReg(r.mem, r.ptr, limitExceeded);
                            n.ptr = r.ptr + 5'h1;
                            n.sdaOe = ~n.txSh[7];
                        end
                        else
                            n.st = SDP_RX;
                    end
                end
            end
            SDP_RX:
            begin
                if (sclRise)
                begin
                    n.rxSh = gotVal;
                    n.bitCnt = r.bitCnt + 3'h1;
                    if (r.bitCnt == 3'h7)
                    begin
                        gotByte = 1'b1;
                        n.st = SDP_RXACK;
                        n.ackOn = 1'b0;
                    end
                end
            end
            SDP_TX:
            begin
                if (sclFall)
                begin
                    n.txSh = {r.txSh[6:0], 1'b0};
                    n.sdaOe = ~r.txSh[6];
                end
                if (sclRise)
                begin
                    n.bitCnt = r.bitCnt + 3'h1;
                    if (r.bitCnt == 3'h7)
                    begin
                        n.st = SDP_TXACK;
                        n.ackOn = 1'b0;
                    end
                end
            end
            SDP_TXACK:
            begin
                if (sclRise)
                    n.nack = sdaLvl;
                if (sclFall)
                begin
                    n.ackOn = ~r.ackOn;
                    n.sdaOe = 1'b0;
                    if (r.ackOn)
                    begin
                        if (r.nack)
                            n.st = SDP_IDLE;
                        else
                        begin
                            n.st = SDP_TX;
                            n.bitCnt = 3'h0;
                            n.txSh = readReg(r.mem, r.ptr, limitExceeded);
                            n.ptr = r.ptr + 5'h1;
                            n.sdaOe = ~n.txSh[7];
                        end
                    end
                end
            end
            SDP_SPI:
            begin
                isSpi = 1'b1;
                if (sclRise)
                begin
                    n.rxSh = gotVal;
                    n.bitCnt = r.bitCnt + 3'h1;
                    gotByte = (r.bitCnt == 3'h7);
                end
                if (sclFall && r.rd)
                begin
                    n.doutOe = ~r.txSh[7];
                    n.txSh = {r.txSh[6:0], 1'b0};
                end
            end
            default:
                n.st = SDP_IDLE;
        endcase

        // completed byte: pointer, read reload or register write
        if (gotByte)
        begin
            if (r.firstByte)
            begin
                n.firstByte = 1'b0;
                n.ptr = gotVal[4:0];
                if (isSpi)
                begin
                    n.rd = gotVal[SPI_RD_BIT];
                    if (gotVal[SPI_RD_BIT])
                    begin
                        n.txSh = readReg(r.mem, gotVal[4:0], limitExceeded);
                        n.ptr = gotVal[4:0] + 5'h1;
                    end
                end
            end
            else if (isSpi && r.rd)
            begin
                n.txSh = readReg(r.mem, r.ptr, limitExceeded);
                n.ptr = r.ptr + 5'h1;
            end
            else
            begin
                wrEn = 1'b1;
                n.ptr = r.ptr + 5'h1;
                if (r.ptr != REG_STATUS)
                    n.mem[r.ptr] = gotVal;
            end
        end

        // framing overrides the byte engine
        if (csLow && r.st != SDP_SPI)
        begin
            n.st = SDP_SPI;
            n.bitCnt = 3'h0;
            n.firstByte = 1'b1;
            n.rd = 1'b0;
            n.sdaOe = 1'b0;
            n.doutOe = 1'b0;
        end
        else if (!csLow && r.st == SDP_SPI)
        begin
            n.st = SDP_IDLE;
            n.doutOe = 1'b0;
        end
        else if (startCond)
        begin
            n.st = SDP_ADDR;
            n.bitCnt = 3'h0;
            n.firstByte = 1'b1;
            n.sdaOe = 1'b0;
        end
        else if (stopCond)
        begin
            n.st = SDP_IDLE;
            n.sdaOe = 1'b0;
        end

        // limit interrupt, polarity from the config bit
        n.intOut = (|limitExceeded) ^ ~r.mem[REG_CFG1][INTPOL_BIT];
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.st <= SDP_IDLE;
            r.mem[REG_CFG1] <= CFG1_RST;
            r.mem[REG_CFG3] <= CFG3_RST;
            r.intOut <= 1'b1;
        end
        else
            r <= n;
    end

    // ----------------------------------------------------------------
    // dac bank
    // ----------------------------------------------------------------
    // a write to the high byte of a channel completes its code
    assign dacWr = wrEn && r.ptr <= REG_DAC_LAST && r.ptr[0];
    assign dacWrCode = DAC_W'({gotVal, r.mem[r.ptr - 5'h1]});
    // strobe only counts while the enable bit is set
    assign loadPulse = pinFall[SI_LOADN] & r.mem[REG_CFG3][LOADEN_BIT];

    sdp_dac_bank #(
        .CH(DAC_CH),
        .W(DAC_W)
    ) u_bank (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(dacWr),
        .wrChan(r.ptr[$clog2(DAC_CH):1]),
        .wrCode(dacWrCode),
        .loadPinEnable(r.mem[REG_CFG3][LOADEN_BIT]),
        .loadPulse(loadPulse),
        .dacCode(dacCode),
        .pending(dacPending)
    );

    // open drain pins only ever pull low
    assign sdaDinOut = 1'b0;
    assign doutAddOut = 1'b0;
    assign sdaDinOe = r.sdaOe;
    assign doutAddOe = r.doutOe;
    assign intPin = r.intOut;
endmodule // sdp_serial_port

// ===== src/sdp_pkg.sv
// shared constants and types for the serial port and dac load block
package sdp_pkg;

    // ----------------------------------------------------------------
    // synchronised pin vector layout
    // ----------------------------------------------------------------
    localparam int SYNC_W = 6;
    localparam int SI_SCLK = 0;
    localparam int SI_CSN = 1;
    localparam int SI_SDA = 2;
    localparam int SI_ADD = 3;
    localparam int SI_FLOAT = 4;
    localparam int SI_LOADN = 5;

    // ----------------------------------------------------------------
    // internal register map (pointer indices)
    // ----------------------------------------------------------------
    localparam int REG_COUNT = 32;
    localparam logic [4:0] REG_DAC_LAST = 5'h07;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_CFG1 = 5'h18;
    localparam logic [4:0] REG_CFG3 = 5'h1a;
    localparam int INTPOL_BIT = 3;
    localparam int LOADEN_BIT = 3;
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG3_RST = 8'h08;
    localparam int SPI_RD_BIT = 7;

    // ----------------------------------------------------------------
    // two-wire address selection
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_PIN_LOW = 7'h48;
    localparam logic [6:0] ADDR_PIN_FLOAT = 7'h4a;
    localparam logic [6:0] ADDR_PIN_HIGH = 7'h4b;
    localparam logic [1:0] ADDR_REPEATS = 2'h2;

    // ----------------------------------------------------------------
    // dac and limit defaults
    // ----------------------------------------------------------------
    localparam int DAC_CH_DEF = 4;
    localparam int DAC_W_DEF = 12;
    localparam int LIMIT_W = 3;

    typedef enum logic [7:0] {
        SDP_IDLE = 8'h01,
        SDP_ADDR = 8'h02,
        SDP_AACK = 8'h04,
        SDP_RX = 8'h08,
        SDP_RXACK = 8'h10,
        SDP_TX = 8'h20,
        SDP_TXACK = 8'h40,
        SDP_SPI = 8'h80
    } sdp_state_t;

endpackage

// ===== src/sdp_pin_sync.sv
// two-flop synchroniser with edge detection for a vector of pins
`timescale 1ns/1ps
module sdp_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // asynchronous pins
    input wire logic [W-1:0] pinIn,
    // synchronised level and edges
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
    } sdp_sync_t;

    sdp_sync_t r;
    sdp_sync_t n;

    if (W < 1)
    begin : g_bad_w
        $error("sdp_pin_sync: W must be at least 1");
    end

    always_comb
    begin
        n = r;
        n.s1 = pinIn;
        n.s2 = r.s1;
        n.prev = r.s2;
    end

    always_ff @(posedge clk)
    begin
        // link and strobe pins rest high, so reset leaves no false edge
        if (sys_rst)
            r <= '1;
        else
            r <= n;
    end

    // edges compare the second stage with its own delayed copy only
    assign lvl = r.s2;
    assign rise = r.s2 & ~r.prev;
    assign fall = ~r.s2 & r.prev;
endmodule // sdp_pin_sync

// ===== src/sdp_dac_bank.sv
// double-buffered dac input and output registers with load strobe
`timescale 1ns/1ps
module sdp_dac_bank #(
    parameter int CH = sdp_pkg::DAC_CH_DEF,
    parameter int W = sdp_pkg::DAC_W_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // input register write
    input wire logic wrEn,
    input wire logic [$clog2(CH)-1:0] wrChan,
    input wire logic [W-1:0] wrCode,
    // load control
    input wire logic loadPinEnable,
    input wire logic loadPulse,
    // dac codes and pending flags
    output logic [CH-1:0][W-1:0] dacCode,
    output logic [CH-1:0] pending
);
    import sdp_pkg::*;

    typedef struct packed {
        logic [CH-1:0][W-1:0] inReg;
        logic [CH-1:0][W-1:0] dacReg;
        logic [CH-1:0] newData;
    } sdp_bank_t;

    sdp_bank_t r;
    sdp_bank_t n;

    if (CH < 2 || W < 1 || W > 16)
    begin : g_bad_cfg
        $error("sdp_dac_bank: CH must be 2 or more, W 1 to 16");
    end

    always_comb
    begin
        n = r;
        for (int i = 0; i < CH; i++)
        begin
            // only channels holding new data move on a strobe
            if (loadPulse && r.newData[i])
            begin
                n.dacReg[i] = r.inReg[i];
                n.newData[i] = 1'b0;
            end
            if (wrEn && wrChan == i[$clog2(CH)-1:0])
            begin
                n.inReg[i] = wrCode;
                // with the pin disabled the write goes straight through
                if (loadPinEnable)
                    n.newData[i] = 1'b1;
                else
                    n.dacReg[i] = wrCode;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            r <= '0;
        else
            r <= n;
    end

    assign dacCode = r.dacReg;
    assign pending = r.newData;
endmodule // sdp_dac_bank

// ===== sim/sdp_serial_port_props.sv
// checker on the serial port top-level ports
`timescale 1ns/1ps
module sdp_serial_port_props #(
    parameter int DAC_CH = 4,
    parameter int DAC_W = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial pins
    input wire logic sclkPin,
    input wire logic csPin_n,
    input wire logic sdaDinIn,
    input wire logic sdaDinOut,
    input wire logic sdaDinOe,
    input wire logic doutAddIn,
    input wire logic doutAddOut,
    input wire logic doutAddOe,
    input wire logic addFloatIn,
    // strobe, limits and results
    input wire logic dac_load_strobe_n,
    input wire logic [sdp_pkg::LIMIT_W-1:0] limitExceeded,
    input wire logic intPin,
    input wire logic [DAC_CH-1:0][DAC_W-1:0] dacCode,
    input wire logic [DAC_CH-1:0] dacPending
);
    import sdp_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ----------
    // sequences
    // ----------
    // clock high longer than the sync delay, so the last fall has already acted
    sequence spiClkHigh;
        (!csPin_n && sclkPin) [*8];
    endsequence
    sequence twiClkHigh;
        (csPin_n && sclkPin) [*8];
    endsequence
    sequence heldPending;
        (dac_load_strobe_n && dacPending != '0) [*8];
    endsequence
    sequence loadWhilePending;
        $fell(dac_load_strobe_n) && (dacPending != '0);
    endsequence
    // a limit dropping across reset leaves the pin at its reset level
    sequence limitGone;
        $fell(|limitExceeded) && !$past(sys_rst);
    endsequence

    // ----------
    // assertions
    // ----------
    AST_INT_RST: assert property ($fell(sys_rst) |-> intPin && !sdaDinOe && !doutAddOe)
        else $error("outputs not idle after reset");
    AST_INT_ON: assert property ($rose(|limitExceeded) |-> ##[1:3] $changed(intPin))
        else $error("interrupt missed a limit");
    AST_INT_OFF: assert property (limitGone |-> ##[1:3] $changed(intPin))
        else $error("interrupt stuck after limit");
    AST_DOUT_IDLE: assert property (csPin_n [*6] |-> !doutAddOe)
        else $error("data out driven outside frame");
    AST_DOUT_HOLD: assert property (spiClkHigh |-> $stable(doutAddOe))
        else $error("data out moved without clock fall");
    AST_SDA_HOLD: assert property (twiClkHigh |-> $stable(sdaDinOe))
        else $error("data line moved while clock high");
    AST_DAC_HOLD: assert property (heldPending |-> $stable(dacCode))
        else $error("dac changed without strobe");
    AST_DAC_LOAD: assert property (loadWhilePending |-> ##[1:8] dacPending == '0)
        else $error("strobe did not load");
endmodule // sdp_serial_port_props

bind sdp_serial_port sdp_serial_port_props #(.DAC_CH(DAC_CH), .DAC_W(DAC_W)) i_props (
    .clk, .sys_rst, .sclkPin, .csPin_n, .sdaDinIn, .sdaDinOut, .sdaDinOe, .doutAddIn,
    .doutAddOut, .doutAddOe, .addFloatIn, .dac_load_strobe_n, .limitExceeded, .intPin,
    .dacCode, .dacPending);

// ===== sim/sdp_host_model.sv
// host model: four-wire and two-wire master on the shared serial pins
`timescale 1ns/1ps
module sdp_host_model (
    // pins towards the device
    output logic sclkPin,
    output logic csPin_n,
    output logic sdaLine,
    // device pull-downs
    input wire logic sdaDinOe,
    input wire logic doutAddOe
);
    // half period of the 125 ns link clock
    localparam realtime HALF = 62.5;
    logic sdaRel = 1'b1;

    // ----------
    // pins
    // ----------
    // open-drain line with pull-up; clock stands high between frames
    assign sdaLine = sdaRel && (sdaDinOe !== 1'b1);
    initial
    begin
        sclkPin = 1'b1;
        csPin_n = 1'b1;
    end

    task automatic spiByte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sclkPin = 1'b0;
            sdaRel = tx[i];
            #(HALF);
            rx[i] = !doutAddOe;
            sclkPin = 1'b1;
            #(HALF);
        end
    endtask

    task automatic spiXfer(input logic [7:0] cmd, input logic [7:0] d, output logic [7:0] rx);
        csPin_n = 1'b0;
        #(HALF);
        spiByte(cmd, rx);
        spiByte(d, rx);
        csPin_n = 1'b1;
        sdaRel = 1'b1;
        #(HALF);
    endtask

    task automatic twiStart;
        sdaRel = 1'b0;
        #(HALF);
        sclkPin = 1'b0;
    endtask

    task automatic twiStop;
        #(HALF / 4);
        sdaRel = 1'b0;
        #(HALF * 3 / 4);
        sclkPin = 1'b1;
        #(HALF / 2);
        sdaRel = 1'b1;
        #(HALF);
    endtask

    // a one bit releases the line so the device may answer in that slot
    task automatic twiBits(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            #(HALF / 4);
            sdaRel = tx[i];
            #(HALF * 3 / 4);
            sclkPin = 1'b1;
            #(HALF / 2);
            rx[i] = sdaLine;
            #(HALF / 2);
            sclkPin = 1'b0;
        end
    endtask

    task automatic twiWr(input logic [6:0] a, input logic [7:0] d, output logic nack);
        logic [8:0] r;
        twiStart();
        twiBits({a, 2'b01}, r);
        nack = r[0];
        if (!nack)
        begin
            twiBits({8'h1c, 1'b1}, r);
            twiBits({d, 1'b1}, r);
        end
        twiStop();
    endtask

    task automatic twiRd(input logic [6:0] a, output logic [7:0] d);
        logic [8:0] r;
        twiStart();
        twiBits({a, 2'b01}, r);
        twiBits({8'h1c, 1'b1}, r);
        twiStop();
        twiStart();
        twiBits({a, 2'b11}, r);
        twiBits(9'h1ff, r);
        d = r[8:1];
        twiStop();
    endtask
endmodule // sdp_host_model

// ===== sim/tb.sv
// self-checking bench for the serial port, address select and dac load
`timescale 1ns/1ps
module tb;
    import sdp_pkg::*;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic loadN = 1'b1;
    logic [2:0] limits = 3'h0;
    logic addLvl = 1'b1;
    logic addFloat = 1'b0;
    logic sclk, csN, sdaLine, sdaOe, doutOe, intPin, nack;
    logic [3:0][11:0] dacCode;
    logic [3:0] pend;
    logic [7:0] rx;
    int numErrors = 0;
    int totalChecks = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    sdp_serial_port i_sdp_serial_port (
        .clk(clk), .sys_rst(sysRst), .sclkPin(sclk), .csPin_n(csN), .sdaDinIn(sdaLine),
        .sdaDinOut(), .sdaDinOe(sdaOe), .doutAddIn(addLvl & (doutOe !== 1'b1)),
        .doutAddOut(), .doutAddOe(doutOe), .addFloatIn(addFloat), .dac_load_strobe_n(loadN),
        .limitExceeded(limits), .intPin(intPin), .dacCode(dacCode), .dacPending(pend));
    sdp_host_model i_sdp_host_model (
        .sclkPin(sclk), .csPin_n(csN), .sdaLine(sdaLine), .sdaDinOe(sdaOe), .doutAddOe(doutOe));

    // ----------
    // helpers
    // ----------
    task automatic results;
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            numErrors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            results();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        totalChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic spiWr(input logic [4:0] ptr, input logic [7:0] d);
        i_sdp_host_model.spiXfer({3'b000, ptr}, d, rx);
        tick(1);
    endtask

    task automatic spiRd(input logic [4:0] ptr);
        i_sdp_host_model.spiXfer({3'b100, ptr}, 8'h00, rx);
        tick(1);
    endtask

    task automatic doReset;
        sysRst = 1'b1;
        tick(8);
        sysRst = 1'b0;
        tick(1);
    endtask

    // ----------
    // scenarios
    // ----------
    task automatic testReset;
        chk(12'(intPin), 12'h001, "int idle");
        spiRd(REG_CFG3);
        chk(12'(rx), 12'h008, "load pin default");
        spiRd(REG_CFG1);
        chk(12'(rx), 12'h000, "polarity default");
        $display("reset test done");
    endtask

    task automatic testSpi;
        for (int i = 0; i < 2; i++)
        begin
            spiWr(5'h1b, i ? 8'h5a : 8'ha5);
            spiRd(5'h1b);
            chk(12'(rx), i ? 12'h05a : 12'h0a5, "four-wire readback");
        end
        limits = 3'h5;
        spiWr(REG_STATUS, 8'hff);
        spiRd(REG_STATUS);
        chk(12'(rx), 12'h005, "status read");
        limits = 3'h0;
        tick(4);
        $display("four-wire test done");
    endtask

    task automatic testInt;
        for (int i = 0; i < 3; i++)
        begin
            limits = 3'(1 << i);
            tick(3);
            chk(12'(intPin), 12'h000, "int low active");
            limits = 3'h0;
            tick(3);
            chk(12'(intPin), 12'h001, "int released");
        end
        spiWr(REG_CFG1, 8'h08);
        tick(3);
        chk(12'(intPin), 12'h000, "high polarity idle");
        limits = 3'h2;
        tick(3);
        chk(12'(intPin), 12'h001, "high polarity active");
        limits = 3'h0;
        spiWr(REG_CFG1, 8'h00);
        $display("interrupt test done");
    endtask

    task automatic testDac;
        spiWr(5'h02, 8'h34);
        spiWr(5'h03, 8'h0b);
        spiWr(5'h06, 8'hcd);
        spiWr(5'h07, 8'h0f);
        chk(12'(pend), 12'h00a, "pending set");
        chk(dacCode[1], 12'h000, "held before strobe");
        loadN = 1'b0;
        tick(6);
        loadN = 1'b1;
        tick(2);
        chk(dacCode[1], 12'hb34, "channel 1 loaded");
        chk(dacCode[3], 12'hfcd, "channel 3 loaded");
        chk(12'(pend), 12'h000, "pending cleared");
        spiWr(REG_CFG3, 8'h00);
        spiWr(5'h00, 8'h21);
        spiWr(5'h01, 8'h08);
        chk(dacCode[0], 12'h821, "direct write");
        chk(12'(pend), 12'h000, "nothing pending");
        spiWr(REG_CFG3, 8'h08);
        $display("dac load test done");
    endtask

    task automatic testAddr;
        logic [6:0] addrs [3] = '{7'h48, 7'h4a, 7'h4b};
        for (int k = 0; k < 3; k++)
        begin
            doReset();
            addFloat = (k == 1);
            addLvl = (k == 2);
            i_sdp_host_model.twiWr(addrs[(k + 1) % 3], 8'h30, nack);
            chk(12'(nack), 12'h001, "foreign address");
            for (int n = 0; n < 2; n++)
            begin
                i_sdp_host_model.twiWr(addrs[k], 8'h30 + 8'(k), nack);
                chk(12'(nack), 12'h000, "own address");
            end
            tick(1);
            addFloat = (k == 0);
            addLvl = (k == 1);
            i_sdp_host_model.twiWr(addrs[k], 8'h30 + 8'(k), nack);
            chk(12'(nack), 12'h000, "latched address");
            i_sdp_host_model.twiWr(addrs[(k + 1) % 3], 8'h30, nack);
            chk(12'(nack), 12'h001, "pin ignored");
            i_sdp_host_model.twiRd(addrs[k], rx);
            chk(12'(rx), 12'h030 + 12'(k), "two-wire read");
            tick(1);
        end
        addFloat = 1'b0;
        addLvl = 1'b1;
        $display("address test done");
    endtask

    initial
    begin
        doReset();
        testReset();
        testSpi();
        testInt();
        testDac();
        testAddr();
        results();
    end
endmodule // tb
